//--- hdl/touch_qual_pkg.sv
// Package of register map, fields and constants for touch qualification
package touch_qual_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_GROUP_TOUCH_CONFIG    = 8'h2A;
  localparam logic [7:0] ADDR_PATTERN_DETECT_CONFIG = 8'h2B;
  localparam logic [7:0] ADDR_PATTERN_SELECT        = 8'h2D;
  localparam logic [7:0] ADDR_BASE_COUNT_LIMIT      = 8'h2E;

  // ****************************************
  // Reset values and write masks
  // ****************************************
  localparam logic [7:0] RST_GROUP_TOUCH_CONFIG    = 8'h80;
  localparam logic [7:0] RST_PATTERN_DETECT_CONFIG = 8'h00;
  localparam logic [7:0] RST_PATTERN_SELECT        = 8'h07;
  localparam logic [7:0] MASK_GROUP_TOUCH_CONFIG   = 8'h8C;
  localparam logic [7:0] MASK_PATTERN_CONFIG       = 8'h8F;
  localparam logic [7:0] MASK_PATTERN_SELECT       = 8'h07;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_GROUP_BLOCK_ENABLE  = 7;
  localparam int LSB_TOUCH_LIMIT         = 2;
  localparam int BIT_PATTERN_ENABLE      = 7;
  localparam int LSB_PATTERN_THRESHOLD   = 2;
  localparam int BIT_PATTERN_COMPARE     = 1;
  localparam int BIT_PATTERN_ALERT       = 0;

  // ****************************************
  // Sizes and threshold scaling
  // ****************************************
  localparam int NUM_INPUTS = 3;
  localparam int CNT_W      = 8;
  localparam int TH_W       = 7;
  localparam logic [1:0] LIMIT_ONE     = 2'h0;
  localparam logic [1:0] LIMIT_TWO     = 2'h1;
  localparam logic [1:0] THR_12P5      = 2'h0;
  localparam logic [1:0] THR_25        = 2'h1;
  localparam logic [1:0] THR_37P5      = 2'h2;
  localparam logic [1:0] THR_100       = 2'h3;
  localparam int THR_EIGHTH_SHIFT = 3;
  localparam int THR_QUARTER_SHIFT = 2;

endpackage : touch_qual_pkg

//--- hdl/pattern_detect.sv
// Pattern and count detector over one sensing cycle of per-input results
`timescale 1ns/1ps
module pattern_detect (
  input  wire logic [touch_qual_pkg::NUM_INPUTS-1:0]               sense_hit,
  input  wire logic [touch_qual_pkg::NUM_INPUTS-1:0]               pattern_bits,
  input  wire logic                                                compare_mode,
  output logic                                                     criterion_met
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [1:0] popcount3(input logic [2:0] v);
    popcount3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction : popcount3

  always_comb begin
    if (compare_mode) begin
      // Every pattern input must hit, other inputs may hit too; empty pattern never matches
      criterion_met = (pattern_bits != 3'h0) && ((sense_hit & pattern_bits) == pattern_bits);
    end else begin
      // Count mode; an empty pattern would trip every cycle, so it is held off
      criterion_met = (pattern_bits != 3'h0) &&
                      (popcount3(sense_hit) >= popcount3(pattern_bits));
    end
  end

endmodule : pattern_detect

//--- hdl/touch_qual.sv
// Touch qualification: group touch limiting, pattern detection, base range
`timescale 1ns/1ps
module touch_qual (
  input  wire logic                                   clk_sys,
  input  wire logic                                   rst,
  // Register port
  input  wire logic [7:0]                             reg_addr,
  input  wire logic [7:0]                             reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output logic [7:0]                                  reg_rdata,
  // Sensing cycle results
  input  wire logic                                   cycle_done,
  input  wire logic [touch_qual_pkg::NUM_INPUTS-1:0]  raw_touch,
  input  wire logic [touch_qual_pkg::NUM_INPUTS-1:0]  noise_flag,
  input  wire logic [touch_qual_pkg::NUM_INPUTS-1:0]  standby_mode,
  input  wire logic [touch_qual_pkg::CNT_W*3-1:0]     delta_count,
  input  wire logic [touch_qual_pkg::TH_W*3-1:0]      active_threshold,
  input  wire logic [touch_qual_pkg::TH_W*3-1:0]      standby_threshold,
  input  wire logic [touch_qual_pkg::NUM_INPUTS-1:0]  base_out_of_range,
  input  wire logic                                   interrupt_clear,
  // Qualified results
  output logic [touch_qual_pkg::NUM_INPUTS-1:0]       touch_flag,
  output logic                                        group_touch_status,
  output logic                                        pattern_event_status,
  output logic                                        pattern_interrupt,
  output logic                                        pattern_alert_request,
  output logic                                        base_range_fault_summary
);

  // ****************************************
  // Configuration registers and base count limit status register
  // ****************************************
  logic [7:0] group_touch_config_reg;
  logic [7:0] pattern_detect_config_reg;
  logic [7:0] pattern_select_reg;
  logic [2:0] base_count_limit_status_reg;

  logic       group_block_enable;
  logic [1:0] simultaneous_touch_limit;
  logic       pattern_detect_enable;
  logic [1:0] pattern_threshold_select;
  logic       pattern_compare_mode;
  logic       pattern_alert_enable;

  assign group_block_enable       = group_touch_config_reg[touch_qual_pkg::BIT_GROUP_BLOCK_ENABLE];
  assign simultaneous_touch_limit =
    group_touch_config_reg[touch_qual_pkg::LSB_TOUCH_LIMIT +: 2];
  assign pattern_detect_enable    = pattern_detect_config_reg[touch_qual_pkg::BIT_PATTERN_ENABLE];
  assign pattern_threshold_select =
    pattern_detect_config_reg[touch_qual_pkg::LSB_PATTERN_THRESHOLD +: 2];
  assign pattern_compare_mode     = pattern_detect_config_reg[touch_qual_pkg::BIT_PATTERN_COMPARE];
  assign pattern_alert_enable     = pattern_detect_config_reg[touch_qual_pkg::BIT_PATTERN_ALERT];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      group_touch_config_reg    <= touch_qual_pkg::RST_GROUP_TOUCH_CONFIG;
      pattern_detect_config_reg <= touch_qual_pkg::RST_PATTERN_DETECT_CONFIG;
      pattern_select_reg        <= touch_qual_pkg::RST_PATTERN_SELECT;
    end else if (reg_wr) begin
      unique case (reg_addr)
        touch_qual_pkg::ADDR_GROUP_TOUCH_CONFIG: begin
          group_touch_config_reg <= reg_wdata & touch_qual_pkg::MASK_GROUP_TOUCH_CONFIG;
        end
        touch_qual_pkg::ADDR_PATTERN_DETECT_CONFIG: begin
          pattern_detect_config_reg <= reg_wdata & touch_qual_pkg::MASK_PATTERN_CONFIG;
        end
        touch_qual_pkg::ADDR_PATTERN_SELECT: begin
          pattern_select_reg <= reg_wdata & touch_qual_pkg::MASK_PATTERN_SELECT;
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        touch_qual_pkg::ADDR_GROUP_TOUCH_CONFIG:    reg_rdata <= group_touch_config_reg;
        touch_qual_pkg::ADDR_PATTERN_DETECT_CONFIG: reg_rdata <= pattern_detect_config_reg;
        touch_qual_pkg::ADDR_PATTERN_SELECT:        reg_rdata <= pattern_select_reg;
        touch_qual_pkg::ADDR_BASE_COUNT_LIMIT: begin
          reg_rdata <= {5'h00, base_count_limit_status_reg};
        end
        default:                                    reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Base count range
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      base_count_limit_status_reg <= 3'h0;
      base_range_fault_summary    <= 1'b0;
    end else begin
      base_count_limit_status_reg <= base_out_of_range;
      base_range_fault_summary    <= |base_out_of_range;
    end
  end

  // ****************************************
  // Pattern threshold and hits
  // ****************************************
  function automatic logic [touch_qual_pkg::TH_W-1:0] scale_threshold(
    input logic [touch_qual_pkg::TH_W-1:0] th,
    input logic [1:0]                      sel
  );
    logic [touch_qual_pkg::TH_W-1:0] eighth;
    logic [touch_qual_pkg::TH_W-1:0] quarter;
    eighth  = th >> touch_qual_pkg::THR_EIGHTH_SHIFT;
    quarter = th >> touch_qual_pkg::THR_QUARTER_SHIFT;
    unique case (sel)
      touch_qual_pkg::THR_12P5: scale_threshold = eighth;
      touch_qual_pkg::THR_25:   scale_threshold = quarter;
      touch_qual_pkg::THR_37P5: scale_threshold = quarter + eighth;
      touch_qual_pkg::THR_100:  scale_threshold = th;
    endcase
  endfunction : scale_threshold

  logic [touch_qual_pkg::NUM_INPUTS-1:0] sense_hit;
  logic                                  criterion_met;

  always_comb begin
    for (int i = 0; i < touch_qual_pkg::NUM_INPUTS; i++) begin
      // Standby inputs compare against the standby threshold
      sense_hit[i] = noise_flag[i] ||
        ({1'b0, delta_count[i*touch_qual_pkg::CNT_W +: touch_qual_pkg::CNT_W]} >
         {2'b00, scale_threshold(standby_mode[i] ?
            standby_threshold[i*touch_qual_pkg::TH_W +: touch_qual_pkg::TH_W] :
            active_threshold[i*touch_qual_pkg::TH_W +: touch_qual_pkg::TH_W],
            pattern_threshold_select)});
    end
  end

  pattern_detect u_pattern_detect (
    .sense_hit     (sense_hit),
    .pattern_bits  (pattern_select_reg[touch_qual_pkg::NUM_INPUTS-1:0]),
    .compare_mode  (pattern_compare_mode),
    .criterion_met (criterion_met)
  );

  // ****************************************
  // Pattern blocking and status
  // ****************************************
  logic pattern_block_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pattern_block_reg <= 1'b0;
    end else if (!pattern_detect_enable) begin
      pattern_block_reg <= 1'b0;
    end else if (cycle_done) begin
      // Fresh decision each cycle, nothing accumulates
      pattern_block_reg <= criterion_met;
    end
  end

  logic pattern_event;
  assign pattern_event = pattern_detect_enable && cycle_done && criterion_met && !pattern_block_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pattern_event_status  <= 1'b0;
      pattern_interrupt     <= 1'b0;
      pattern_alert_request <= 1'b0;
    end else begin
      pattern_interrupt     <= pattern_event;
      pattern_alert_request <= pattern_event && pattern_alert_enable;
      // Set wins over clear; clear only after condition gone
      if (pattern_event) begin
        pattern_event_status <= 1'b1;
      end else if (interrupt_clear && !pattern_block_reg) begin
        pattern_event_status <= 1'b0;
      end
    end
  end

  // ****************************************
  // Group touch limiting
  // ****************************************
  function automatic logic [1:0] limit_count(input logic [1:0] field);
    unique case (field)
      touch_qual_pkg::LIMIT_ONE: limit_count = 2'd1;
      touch_qual_pkg::LIMIT_TWO: limit_count = 2'd2;
      default:                   limit_count = 2'd3;
    endcase
  endfunction : limit_count

  logic [touch_qual_pkg::NUM_INPUTS-1:0] accepted_reg;
  logic [touch_qual_pkg::NUM_INPUTS-1:0] accepted_next;
  logic                                  over_limit;

  always_comb begin
    logic       released;
    logic [1:0] slots;
    released      = |(accepted_reg & ~raw_touch);
    accepted_next = accepted_reg;
    over_limit    = 1'b0;
    slots         = limit_count(simultaneous_touch_limit);
    // A lowered limit also forces a fresh pick, so no stale set stays over it
    if (released || accepted_reg == 3'h0 || $countones(accepted_reg) > int'(slots)) begin
      // Reselect from scratch in input order
      accepted_next = 3'h0;
      for (int i = 0; i < touch_qual_pkg::NUM_INPUTS; i++) begin
        if (raw_touch[i]) begin
          if (slots != 2'd0) begin
            accepted_next[i] = 1'b1;
            slots            = slots - 2'd1;
          end else begin
            over_limit = 1'b1;
          end
        end
      end
    end else begin
      // Keep latched set; newcomers are blocked
      over_limit = |(raw_touch & ~accepted_reg);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      accepted_reg       <= 3'h0;
      group_touch_status <= 1'b0;
      touch_flag         <= 3'h0;
    end else if (cycle_done) begin
      accepted_reg <= accepted_next;
      if (pattern_detect_enable && criterion_met) begin
        touch_flag         <= 3'h0;
        group_touch_status <= 1'b0;
      end else if (!group_block_enable) begin
        touch_flag         <= raw_touch;
        group_touch_status <= 1'b0;
      end else begin
        touch_flag         <= accepted_next;
        group_touch_status <= over_limit;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_disabled_pass;
    @(posedge clk_sys) disable iff (rst)
    (cycle_done && !group_block_enable && !(pattern_detect_enable && criterion_met))
      |=> (touch_flag == $past(raw_touch));
  endproperty
  a_disabled_pass: assert property (p_disabled_pass) else $error("touch not passed");

  property p_limit_held;
    @(posedge clk_sys) disable iff (rst)
    (cycle_done && group_block_enable) |->
      ($countones(accepted_next) <= limit_count(simultaneous_touch_limit));
  endproperty
  a_limit_held: assert property (p_limit_held) else $error("too many accepted");

  property p_group_status;
    @(posedge clk_sys) disable iff (rst)
    (cycle_done && group_block_enable && over_limit && !(pattern_detect_enable && criterion_met))
      |=> group_touch_status;
  endproperty
  a_group_status: assert property (p_group_status) else $error("group status missing");

  property p_pattern_off;
    @(posedge clk_sys) disable iff (rst)
    !pattern_detect_enable |=> !pattern_interrupt;
  endproperty
  a_pattern_off: assert property (p_pattern_off) else $error("event while disabled");

  sequence s_event;
    pattern_event;
  endsequence
  property p_event_blocks;
    @(posedge clk_sys) disable iff (rst)
    s_event |=> (touch_flag == 3'h0) && pattern_interrupt && pattern_event_status;
  endproperty
  a_event_blocks: assert property (p_event_blocks) else $error("event did not block");

  property p_alert_gate;
    @(posedge clk_sys) disable iff (rst)
    s_event |=> (pattern_alert_request == $past(pattern_alert_enable));
  endproperty
  a_alert_gate: assert property (p_alert_gate) else $error("alert gating wrong");

  property p_status_hold;
    @(posedge clk_sys) disable iff (rst)
    (pattern_event_status && !interrupt_clear) |=> pattern_event_status;
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status cleared alone");

  property p_base_summary;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> (base_range_fault_summary == |$past(base_out_of_range));
  endproperty
  a_base_summary: assert property (p_base_summary) else $error("summary mismatch");

  property p_reserved_zero;
    @(posedge clk_sys) disable iff (rst)
    group_touch_config_reg[6:4] == 3'h0 && pattern_select_reg[7:3] == 5'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

endmodule : touch_qual

//--- bench/host_model.sv
// Host side model: register port access and interrupt clear
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            interrupt_clear
);
  // ****************************************
  // Register port tasks
  // ****************************************
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    interrupt_clear = 1'b0;
  end

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge clk_sys);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    // Idle bus shows inverted values, never the stale ones
    reg_addr  <= ~addr;
    reg_wdata <= ~data;
  endtask : reg_write

  task automatic reg_read(input logic [7:0] addr, output logic [7:0] data);
    @(posedge clk_sys);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    reg_addr <= ~addr;
    #1;
    data = reg_rdata;
  endtask : reg_read

  // Host pulses interrupt_clear high for one clock cycle
  task automatic clear_int();
    @(posedge clk_sys);
    interrupt_clear <= 1'b1;
    @(posedge clk_sys);
    interrupt_clear <= 1'b0;
    #1;
  endtask : clear_int
endmodule : host_model

//--- bench/tb.sv
// Testbench for touch qualification through register calls and sensing cycles
`timescale 1ns/1ps
module tb;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd, interrupt_clear;
  logic        cycle_done = 1'b0;
  logic [2:0]  raw_touch = 3'h0, noise_flag = 3'h0, standby_mode = 3'h0;
  logic [2:0]  base_out_of_range = 3'h0, touch_flag;
  logic [23:0] delta_count = 24'h00_0000;
  logic [20:0] active_threshold = {3{7'h40}};
  logic [20:0] standby_threshold = {3{7'h20}};
  logic        group_touch_status, pattern_event_status, pattern_interrupt;
  logic        pattern_alert_request, base_range_fault_summary;
  int          err_total = 0;
  int          tests_run = 0;

  always #50 clk_sys = ~clk_sys;

  host_model i_host_model (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .interrupt_clear(interrupt_clear));

  touch_qual i_touch_qual (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cycle_done(cycle_done), .raw_touch(raw_touch), .noise_flag(noise_flag),
    .standby_mode(standby_mode), .delta_count(delta_count),
    .active_threshold(active_threshold), .standby_threshold(standby_threshold),
    .base_out_of_range(base_out_of_range), .interrupt_clear(interrupt_clear),
    .touch_flag(touch_flag), .group_touch_status(group_touch_status),
    .pattern_event_status(pattern_event_status), .pattern_interrupt(pattern_interrupt),
    .pattern_alert_request(pattern_alert_request),
    .base_range_fault_summary(base_range_fault_summary));

  // ****************************************
  // Helpers
  // ****************************************
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    i_host_model.reg_read(addr, d);
    chk("register", d, exp);
  endtask : rchk

  task automatic sense(input logic [2:0] raw, input logic [2:0] nz, input logic [2:0] sb,
                       input logic [7:0] d1, input logic [7:0] d2, input logic [7:0] d3);
    @(posedge clk_sys);
    raw_touch    <= raw;
    noise_flag   <= nz;
    standby_mode <= sb;
    delta_count  <= {d3, d2, d1};
    cycle_done   <= 1'b1;
    @(posedge clk_sys);
    cycle_done   <= 1'b0;
    #1;
  endtask : sense

  // Flags, group status, pattern status, interrupt, alert in one compare
  task automatic outs(input logic [2:0] f, input logic g, input logic p, input logic i,
                      input logic a);
    chk("outputs", {1'b0, touch_flag, group_touch_status, pattern_event_status,
        pattern_interrupt, pattern_alert_request}, {1'b0, f, g, p, i, a});
  endtask : outs

  // Truncating scale of a threshold
  function automatic logic [7:0] scaled(input logic [6:0] th, input logic [1:0] c);
    case (c)
      2'h0:    return {1'b0, th >> 3};
      2'h1:    return {1'b0, th >> 2};
      2'h2:    return {1'b0, th >> 2} + {1'b0, th >> 3};
      default: return {1'b0, th};
    endcase
  endfunction : scaled

  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    give_verdict();
  end

  initial begin
    logic [7:0] th;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rchk(8'h2A, 8'h80);
    rchk(8'h2B, 8'h00);
    rchk(8'h2D, 8'h07);
    rchk(8'h2E, 8'h00);
    rchk(8'h2C, 8'h00);
    outs(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
    i_host_model.reg_write(8'h2A, 8'hFF);
    rchk(8'h2A, 8'h8C);
    i_host_model.reg_write(8'h2B, 8'hFF);
    rchk(8'h2B, 8'h8F);
    i_host_model.reg_write(8'h2D, 8'hFF);
    rchk(8'h2D, 8'h07);
    i_host_model.reg_write(8'h2E, 8'hFF);
    rchk(8'h2E, 8'h00);
    @(posedge clk_sys);
    base_out_of_range <= 3'h5;
    rchk(8'h2E, 8'h05);
    chk("summary", {7'h0, base_range_fault_summary}, 8'h01);
    @(posedge clk_sys);
    base_out_of_range <= 3'h0;
    rchk(8'h2E, 8'h00);
    chk("summary", {7'h0, base_range_fault_summary}, 8'h00);
    i_host_model.reg_write(8'h2B, 8'h00);
    for (int t = 0; t < 4; t++) begin
      i_host_model.reg_write(8'h2A, 8'h80 | 8'(t << 2));
      sense(3'h0, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
      sense(3'h7, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
      outs((t == 0) ? 3'h1 : (t == 1) ? 3'h3 : 3'h7, t < 2, 1'b0, 1'b0, 1'b0);
    end
    i_host_model.reg_write(8'h2A, 8'h80);
    sense(3'h0, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
    sense(3'h6, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
    outs(3'h2, 1'b1, 1'b0, 1'b0, 1'b0);
    sense(3'h7, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
    outs(3'h2, 1'b1, 1'b0, 1'b0, 1'b0);
    sense(3'h5, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
    outs(3'h1, 1'b1, 1'b0, 1'b0, 1'b0);
    i_host_model.reg_write(8'h2A, 8'h00);
    sense(3'h7, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
    outs(3'h7, 1'b0, 1'b0, 1'b0, 1'b0);
    // Pattern of inputs 1 and 2, compare mode, each threshold code
    i_host_model.reg_write(8'h2D, 8'h03);
    for (int t = 0; t < 4; t++) begin
      th = scaled(7'h40, 2'(t));
      i_host_model.reg_write(8'h2B, 8'h82 | 8'(t << 2));
      sense(3'h1, 3'h0, 3'h0, th, th + 8'h01, 8'hFF);
      outs(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
      sense(3'h1, 3'h0, 3'h0, th + 8'h01, th, 8'h00);
      outs(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
      sense(3'h1, 3'h0, 3'h0, th + 8'h01, th + 8'h01, 8'h00);
      outs(3'h0, 1'b0, 1'b1, 1'b1, 1'b0);
      sense(3'h1, 3'h0, 3'h0, th + 8'h01, th + 8'h01, 8'h00);
      outs(3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
      i_host_model.clear_int();
      outs(3'h0, 1'b0, 1'b1, 1'b0, 1'b0);
      sense(3'h1, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
      outs(3'h1, 1'b0, 1'b1, 1'b0, 1'b0);
      i_host_model.clear_int();
      outs(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    end
    // Count mode, standby threshold, noise flag, alert enabled
    i_host_model.reg_write(8'h2B, 8'h81);
    sense(3'h1, 3'h4, 3'h1, 8'h04, 8'h00, 8'h00);
    outs(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    sense(3'h1, 3'h4, 3'h1, 8'h05, 8'h00, 8'h00);
    outs(3'h0, 1'b0, 1'b1, 1'b1, 1'b1);
    sense(3'h1, 3'h0, 3'h0, 8'h00, 8'h00, 8'h00);
    i_host_model.clear_int();
    outs(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    i_host_model.reg_write(8'h2B, 8'h83);
    sense(3'h1, 3'h4, 3'h1, 8'h05, 8'h00, 8'h00);
    outs(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    i_host_model.reg_write(8'h2B, 8'h00);
    sense(3'h1, 3'h7, 3'h0, 8'hFF, 8'hFF, 8'hFF);
    outs(3'h1, 1'b0, 1'b0, 1'b0, 1'b0);
    give_verdict();
  end
endmodule : tb
